// >>> bench/testbench.sv
`timescale 1ns/10ps
// ****************************************************************
// signals and instances
// ****************************************************************
module testbench
  import tx_err_mon_pkg::*;
;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, irq, reinit;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic link_running = 1'b1;
  logic [LANES-1:0] gb_over = '0;
  logic [LANES-1:0] gb_under = '0;
  logic [LANES-1:0] fifo_full = '0;
  logic [LANES-1:0] xrdy = '1;
  logic sysref = 1'b0;
  logic [2:0] starve = 3'b000;
  logic [2:0] rdy = 3'b111;
  hs_t cmd, smp, lnk;
  int err_total = 0;
  int compares = 0;
  int pulses = 0;

  tx_link_error_monitor tx_link_error_monitor_i (
    .clk(clk), .srst(srst),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .link_running(link_running),
    .gearbox_over_flag(gb_over), .gearbox_under_flag(gb_under),
    .lane_fifo_full(fifo_full), .lane_xcvr_ready(xrdy), .command_in(cmd),
    .sample_in(smp), .link_data_in(lnk), .sysref(sysref), .irq(irq),
    .link_reinit_req(reinit)
  );

  upstream_source upstream_source_i (
    .clk(clk), .starve(starve), .rdy(rdy), .cmd(cmd), .smp(smp), .lnk(lnk)
  );

  // clock and reinit pulse counter
  always #5 clk = ~clk;
  always @(posedge clk) begin
    if (reinit === 1'b1) pulses++;
  end

  // ****************************************************************
  // shared tasks
  // ****************************************************************
  task automatic summarize();
    $display("errors %0d compares %0d", err_total, compares);
    if (err_total == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic stuck(input int n);
    err_total++;
    $display("Error at %0t: wait got %h expected %h", $time, n, 0);
    summarize();
  endtask

  // bus write, both channels offered together
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er = RESP_OKAY);
    int n;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge clk);
      if (awvalid && awready === 1'b1) awvalid <= 1'b0;
      if (wvalid && wready === 1'b1) wvalid <= 1'b0;
      if (bvalid === 1'b1) break;
    end
    bready <= 1'b0;
    if (n == 50) stuck(n);
    chk(bresp, er);
  endtask

  // bus read with expected data and response
  task automatic rd(input logic [7:0] a, input logic [31:0] exp,
                    input logic [1:0] er = RESP_OKAY);
    int n;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge clk);
      if (arvalid && arready === 1'b1) arvalid <= 1'b0;
      if (rvalid === 1'b1) break;
    end
    rready <= 1'b0;
    if (n == 50) stuck(n);
    chk(rdata, exp);
    chk(rresp, er);
  endtask

  // one-cycle error condition for flag bit b
  task automatic hit(input int b);
    @(posedge clk);
    case (b)
      1: starve <= 3'b100;
      2: starve <= 3'b010;
      3: starve <= 3'b001;
      4: xrdy[15] <= 1'b0;
      5: fifo_full[3] <= 1'b1;
      7: gb_under[0] <= 1'b1;
      default: gb_over[9] <= 1'b1;
    endcase
    @(posedge clk);
    starve <= 3'b000;
    xrdy <= '1;
    fifo_full <= '0;
    gb_under <= '0;
    gb_over <= '0;
    repeat (3) @(posedge clk);
  endtask

  // sysref pulse, next rise g cycles after this one
  task automatic sref(input int g);
    @(posedge clk);
    sysref <= 1'b1;
    repeat (4) @(posedge clk);
    sysref <= 1'b0;
    repeat (g - 5) @(posedge clk);
  endtask

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_reset();
    rd(OFS_FLAGS, 32'h0);
    rd(OFS_IRQ_EN, 32'h1b1);
    rd(OFS_REINIT_EN, 32'h0);
    rd(8'h70, 32'h0, RESP_SLVERR);
    wr(8'h74, 32'hffffffff, RESP_SLVERR);
    chk(irq, 32'h0);
  endtask

  task automatic t_events();
    int bits[7] = '{1, 2, 3, 4, 5, 7, 8};
    wr(OFS_CTRL, 32'h0106);
    foreach (bits[i]) begin
      hit(bits[i]);
      rd(OFS_FLAGS, 32'h1 << bits[i]);
      chk(irq, (32'h1b1 >> bits[i]) & 32'h1);
      wr(OFS_FLAGS, 32'h1 << bits[i]);
      rd(OFS_FLAGS, 32'h0);
    end
  endtask

  task automatic t_sticky();
    hit(1);
    wr(OFS_FLAGS, 32'h0);
    rd(OFS_FLAGS, 32'h2);
    chk(irq, 32'h0);
    wr(OFS_IRQ_EN, 32'hffffffff);
    rd(OFS_IRQ_EN, 32'h1bf);
    chk(irq, 32'h1);
    wr(OFS_FLAGS, 32'h2);
    rd(OFS_FLAGS, 32'h0);
    chk(irq, 32'h0);
    wr(OFS_IRQ_EN, 32'h1b1);
  endtask

  task automatic t_reinit();
    int p0;
    p0 = pulses;
    hit(8);
    chk(pulses, p0);
    wr(OFS_FLAGS, 32'h100);
    wr(OFS_REINIT_EN, 32'h100);
    rd(OFS_REINIT_EN, 32'h100);
    hit(7);
    chk(pulses, p0);
    hit(8);
    chk(pulses, p0 + 1);
    wr(OFS_FLAGS, 32'h180);
    wr(OFS_REINIT_EN, 32'h0);
  endtask

  task automatic t_sysref();
    wr(OFS_CTRL, 32'h0107);
    sref(32);
    sref(64);
    sref(32);
    sref(32);
    rd(OFS_FLAGS, 32'h0);
    wr(OFS_CTRL, 32'h0106);
    wr(OFS_CTRL, 32'h0107);
    sref(32);
    sref(40);
    sref(32);
    rd(OFS_FLAGS, 32'h1);
    chk(irq, 32'h1);
    wr(OFS_FLAGS, 32'h1);
  endtask

  // events masked by a stopped link or an unused channel
  task automatic t_gates();
    wr(OFS_CTRL, 32'h0100);
    hit(3);
    hit(2);
    rd(OFS_FLAGS, 32'h0);
    link_running <= 1'b0;
    hit(1);
    hit(4);
    hit(5);
    rd(OFS_FLAGS, 32'h0);
    link_running <= 1'b1;
  endtask

  // pcfifo error recovered by transceiver reset, then link reset
  task automatic t_recover();
    hit(5);
    chk(irq, 32'h1);
    xrdy <= '0;
    repeat (2) @(posedge clk);
    rd(OFS_FLAGS, 32'h30);
    wr(OFS_IRQ_EN, 32'h0);
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    xrdy <= '1;
    rd(OFS_FLAGS, 32'h0);
    rd(OFS_IRQ_EN, 32'h1b1);
    chk(irq, 32'h0);
  endtask

  // main sequence
  initial begin
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    t_reset();
    t_events();
    t_sticky();
    t_gates();
    t_reinit();
    t_recover();
    t_sysref();
    summarize();
  end
endmodule

// >>> bench/upstream_source.sv
`timescale 1ns/10ps
// ****************************************************************
// upstream source model: command, sample and link data sources
// ****************************************************************
module upstream_source
  import tx_err_mon_pkg::*;
(
  input wire logic clk,
  input wire logic [2:0] starve,
  input wire logic [2:0] rdy,
  output hs_t cmd,
  output hs_t smp,
  output hs_t lnk
);
  logic [2:0] vld_ff;

  // valid stays up with zero latency unless the bench orders a gap
  always_ff @(posedge clk) begin
    vld_ff <= ~starve;
  end

  // ready comes from the consuming layer, passed through
  assign cmd = '{valid: vld_ff[0], ready: rdy[0]};
  assign smp = '{valid: vld_ff[1], ready: rdy[1]};
  assign lnk = '{valid: vld_ff[2], ready: rdy[2]};
endmodule

// >>> src/lane_event_detect.sv
`timescale 1ns/10ps
// ****************************************************************
// per-lane fifo-full rise and ready drop detection
// ****************************************************************
module lane_event_detect
  import tx_err_mon_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic link_running,
  input wire logic [LANES-1:0] lane_fifo_full,
  input wire logic [LANES-1:0] lane_xcvr_ready,
  output logic fifo_full_rise,
  output logic ready_drop
);

  lane_state_t st_ff;
  lane_state_t nxt_st;
  logic [LANES-1:0] full_rise;
  logic [LANES-1:0] rdy_fall;

  // two edge detectors per lane: fifo-full rise and ready fall
  for (genvar i = 0; i < LANES; i++) begin : g_lane
    assign full_rise[i] = lane_fifo_full[i] & ~st_ff.prev_full[i];
    assign rdy_fall[i] = ~lane_xcvr_ready[i] & st_ff.prev_ready[i];
  end

  // any lane, only while the link runs
  assign fifo_full_rise = link_running & (|full_rise);
  assign ready_drop = link_running & (|rdy_fall);

  // history update
  always_comb begin
    nxt_st.prev_full = lane_fifo_full;
    nxt_st.prev_ready = lane_xcvr_ready;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  property p_lane_drop;
    @(posedge clk) disable iff (srst)
    (link_running && st_ff.prev_ready[0] && !lane_xcvr_ready[0]) |-> ready_drop;
  endproperty
  a_lane_drop: assert property (p_lane_drop) else $error("ready drop missed");

endmodule

// >>> src/lemc_period_check.sv
`timescale 1ns/10ps
// ****************************************************************
// sysref period against extended multiblock length
// ****************************************************************
module lemc_period_check
  import tx_err_mon_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic always_on,
  input wire logic [EW-1:0] lemc_e,
  input wire logic sysref_lvl,
  output logic period_err
);

  lemc_state_t st_ff;
  lemc_state_t nxt_st;
  logic [CW-1:0] lim;
  logic edge_seen;

  // period length e*32, e of zero taken as one
  assign lim = (lemc_e == '0) ? {LEMC_E_RST, LEMC_UNIT_ZEROS} : {lemc_e, LEMC_UNIT_ZEROS};
  assign edge_seen = sysref_lvl & ~st_ff.prev;
  // edge off a multiple of the period
  assign period_err = always_on & edge_seen & st_ff.seen & (st_ff.cnt != lim - 1'b1);

  // counter restarts at each edge, wraps each period
  always_comb begin
    nxt_st = st_ff;
    nxt_st.prev = sysref_lvl;
    if (!always_on) begin
      nxt_st.seen = 1'b0;
      nxt_st.cnt = '0;
    end else if (edge_seen) begin
      nxt_st.seen = 1'b1;
      nxt_st.cnt = '0;
    end else if (st_ff.cnt >= lim - 1'b1) begin
      nxt_st.cnt = '0;
    end else begin
      nxt_st.cnt = st_ff.cnt + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  property p_lemc_quiet;
    @(posedge clk) disable iff (srst)
    !always_on |-> !period_err;
  endproperty
  a_lemc_quiet: assert property (p_lemc_quiet) else $error("sysref error while off");

endmodule

// >>> src/tx_err_mon_pkg.sv
// ****************************************************************
// shared constants and types
// ****************************************************************
package tx_err_mon_pkg;

  // lane count and field widths
  localparam int LANES = 16;
  localparam int EW = 8;
  localparam int CW = 13;
  localparam int FW = 9;

  // register byte offsets
  localparam logic [7:0] OFS_FLAGS = 8'h60;
  localparam logic [7:0] OFS_IRQ_EN = 8'h64;
  localparam logic [7:0] OFS_REINIT_EN = 8'h68;
  localparam logic [7:0] OFS_CTRL = 8'h6c;

  // error flag bit positions
  localparam int BIT_LEMC = 0;
  localparam int BIT_LINK_DATA = 1;
  localparam int BIT_FRAME_DATA = 2;
  localparam int BIT_CMD = 3;
  localparam int BIT_XCVR_RDY = 4;
  localparam int BIT_PCFIFO = 5;
  localparam int BIT_GB_UNDER = 7;
  localparam int BIT_GB_OVER = 8;

  // control register field positions
  localparam int BIT_ALWAYS_ON = 0;
  localparam int BIT_CMD_USED = 1;
  localparam int BIT_TP_USED = 2;
  localparam int POS_LEMC_E = 8;

  // implemented bits and reset values
  localparam logic [FW-1:0] FLAG_MASK = 9'h1bf;
  localparam logic [FW-1:0] FLAGS_RST = 9'h000;
  localparam logic [FW-1:0] IRQ_EN_RST = 9'h1b1;
  localparam logic [FW-1:0] REINIT_EN_RST = 9'h000;
  localparam logic [EW-1:0] LEMC_E_RST = 8'h01;
  localparam logic [4:0] LEMC_UNIT_ZEROS = 5'h00;

  // bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // valid/ready pair of a streaming or command port
  typedef struct packed {
    logic valid;
    logic ready;
  } hs_t;

  // per-lane history for edge detection
  typedef struct packed {
    logic [LANES-1:0] prev_full;
    logic [LANES-1:0] prev_ready;
  } lane_state_t;

  // sysref period checker state
  typedef struct packed {
    logic prev;
    logic seen;
    logic [CW-1:0] cnt;
  } lemc_state_t;

  // monitor top state
  typedef struct packed {
    logic [FW-1:0] flags;
    logic [FW-1:0] irq_en;
    logic [FW-1:0] reinit_en;
    logic always_on;
    logic cmd_used;
    logic tp_used;
    logic [EW-1:0] lemc_e;
    logic aw_got;
    logic w_got;
    logic [7:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic irq;
    logic reinit_req;
    logic sysref_s1;
    logic sysref_s2;
  } mon_state_t;

endpackage

// >>> src/tx_link_error_monitor.sv
// Our own choices: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/10ps
// Behaviour
// - lane pcfifo full while running sets flag
// - lane ready drop while running sets flag
// - command ready without valid sets flag
// - sample ready without valid sets flag
// - link ready without valid sets flag
// - sysref off e*32 multiple sets flag
// - interrupt only for enabled flags
// - interrupt enables reset to 0x1b1
// - reinit only for reinit-enabled flags
// - reinit enables reset to zero
// - reinit never resets the transceiver
// - gearbox overflow bit 8, underflow bit 7
// - any enabled flag raises interrupt
module tx_link_error_monitor
  import tx_err_mon_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic link_running,
  input wire logic [LANES-1:0] gearbox_over_flag,
  input wire logic [LANES-1:0] gearbox_under_flag,
  input wire logic [LANES-1:0] lane_fifo_full,
  input wire logic [LANES-1:0] lane_xcvr_ready,
  input wire hs_t command_in,
  input wire hs_t sample_in,
  input wire hs_t link_data_in,
  input wire logic sysref,
  output logic irq,
  output logic link_reinit_req
);

  // ****************************************************************
  // decode helpers
  // ****************************************************************

  // word-aligned offset is one of the four registers
  function automatic logic is_mapped(input logic [7:0] a);
    logic [7:0] w;
    w = {a[7:2], 2'b00};
    return (w == OFS_FLAGS) || (w == OFS_IRQ_EN) || (w == OFS_REINIT_EN) || (w == OFS_CTRL);
  endfunction

  // byte strobes widened to bit mask
  function automatic logic [31:0] strb_mask(input logic [3:0] s);
    return {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
  endfunction

  // control register image
  function automatic logic [31:0] ctrl_word(input mon_state_t s);
    logic [31:0] v;
    v = '0;
    v[BIT_ALWAYS_ON] = s.always_on;
    v[BIT_CMD_USED] = s.cmd_used;
    v[BIT_TP_USED] = s.tp_used;
    v[POS_LEMC_E +: EW] = s.lemc_e;
    return v;
  endfunction

  // read data for a mapped offset, zero elsewhere
  function automatic logic [31:0] read_word(input logic [7:0] a, input mon_state_t s);
    logic [7:0] w;
    logic [31:0] v;
    w = {a[7:2], 2'b00};
    v = '0;
    if (w == OFS_FLAGS) begin
      v[FW-1:0] = s.flags;
    end else if (w == OFS_IRQ_EN) begin
      v[FW-1:0] = s.irq_en;
    end else if (w == OFS_REINIT_EN) begin
      v[FW-1:0] = s.reinit_en;
    end else if (w == OFS_CTRL) begin
      v = ctrl_word(s);
    end
    return v;
  endfunction

  // ****************************************************************
  // state and event sources
  // ****************************************************************

  mon_state_t st_ff;
  mon_state_t nxt_st;
  logic fifo_full_rise;
  logic ready_drop;
  logic lemc_err;
  logic [FW-1:0] ev;
  logic [FW-1:0] clr;
  logic wr_fire;
  logic [31:0] m;
  logic [7:0] wword;

  // lane history for fifo and ready edges
  lane_event_detect u_lanes (
    .clk(clk),
    .srst(srst),
    .link_running(link_running),
    .lane_fifo_full(lane_fifo_full),
    .lane_xcvr_ready(lane_xcvr_ready),
    .fifo_full_rise(fifo_full_rise),
    .ready_drop(ready_drop)
  );

  // sysref period check on the synchronised level
  lemc_period_check u_lemc (
    .clk(clk),
    .srst(srst),
    .always_on(st_ff.always_on),
    .lemc_e(st_ff.lemc_e),
    .sysref_lvl(st_ff.sysref_s2),
    .period_err(lemc_err)
  );

  // error events of this cycle
  always_comb begin
    ev = '0;
    ev[BIT_GB_OVER] = |gearbox_over_flag;
    ev[BIT_GB_UNDER] = |gearbox_under_flag;
    ev[BIT_PCFIFO] = fifo_full_rise;
    ev[BIT_XCVR_RDY] = ready_drop;
    // ready high with valid low breaks the zero-latency contract
    ev[BIT_CMD] = st_ff.cmd_used & link_running & command_in.ready & ~command_in.valid;
    ev[BIT_FRAME_DATA] = st_ff.tp_used & link_running & sample_in.ready
      & ~sample_in.valid;
    ev[BIT_LINK_DATA] = link_running & link_data_in.ready & ~link_data_in.valid;
    ev[BIT_LEMC] = lemc_err;
  end

  // ****************************************************************
  // next state
  // ****************************************************************

  assign wr_fire = st_ff.aw_got & st_ff.w_got & ~st_ff.bvalid;
  assign m = strb_mask(st_ff.wstrb);
  assign wword = {st_ff.awaddr[7:2], 2'b00};

  always_comb begin
    nxt_st = st_ff;
    clr = '0;
    // sysref pin synchroniser
    nxt_st.sysref_s1 = sysref;
    nxt_st.sysref_s2 = st_ff.sysref_s1;
    // write address and data taken in either order
    if (s_axi_awvalid && st_ff.awready) begin
      nxt_st.aw_got = 1'b1;
      nxt_st.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && st_ff.wready) begin
      nxt_st.w_got = 1'b1;
      nxt_st.wdata = s_axi_wdata;
      nxt_st.wstrb = s_axi_wstrb;
    end
    if (st_ff.bvalid && s_axi_bready) begin
      nxt_st.bvalid = 1'b0;
    end
    // register update once both halves are held
    if (wr_fire) begin
      nxt_st.aw_got = 1'b0;
      nxt_st.w_got = 1'b0;
      nxt_st.bvalid = 1'b1;
      nxt_st.bresp = is_mapped(st_ff.awaddr) ? RESP_OKAY : RESP_SLVERR;
      if (wword == OFS_FLAGS) begin
        clr = st_ff.wdata[FW-1:0] & m[FW-1:0] & FLAG_MASK;
      end else if (wword == OFS_IRQ_EN) begin
        nxt_st.irq_en = ((st_ff.irq_en & ~m[FW-1:0]) | (st_ff.wdata[FW-1:0] & m[FW-1:0]))
          & FLAG_MASK;
      end else if (wword == OFS_REINIT_EN) begin
        nxt_st.reinit_en = ((st_ff.reinit_en & ~m[FW-1:0]) | (st_ff.wdata[FW-1:0] & m[FW-1:0]))
          & FLAG_MASK;
      end else if (wword == OFS_CTRL) begin
        if (st_ff.wstrb[0]) begin
          nxt_st.always_on = st_ff.wdata[BIT_ALWAYS_ON];
          nxt_st.cmd_used = st_ff.wdata[BIT_CMD_USED];
          nxt_st.tp_used = st_ff.wdata[BIT_TP_USED];
        end
        if (st_ff.wstrb[1]) begin
          nxt_st.lemc_e = st_ff.wdata[POS_LEMC_E +: EW];
        end
      end
    end
    nxt_st.awready = ~nxt_st.aw_got & ~nxt_st.bvalid;
    nxt_st.wready = ~nxt_st.w_got & ~nxt_st.bvalid;
    // read channel: data captured at the address handshake
    if (st_ff.rvalid && s_axi_rready) begin
      nxt_st.rvalid = 1'b0;
    end
    if (s_axi_arvalid && st_ff.arready) begin
      nxt_st.rvalid = 1'b1;
      nxt_st.rdata = read_word(s_axi_araddr, st_ff);
      nxt_st.rresp = is_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
    end
    nxt_st.arready = ~nxt_st.rvalid;
    // sticky flags, a new event wins over a clear
    nxt_st.flags = ((st_ff.flags & ~clr) | ev) & FLAG_MASK;
    // level interrupt from enabled flags
    nxt_st.irq = |(nxt_st.flags & nxt_st.irq_en);
    // pulse when a flag newly meets its reinit enable; link only, no transceiver reset
    nxt_st.reinit_req = |(nxt_st.flags & nxt_st.reinit_en & ~(st_ff.flags & st_ff.reinit_en));
  end

  // ****************************************************************
  // registers
  // ****************************************************************

  always_ff @(posedge clk) begin
    if (srst) begin
      st_ff <= '{
        flags: FLAGS_RST,
        irq_en: IRQ_EN_RST,
        reinit_en: REINIT_EN_RST,
        lemc_e: LEMC_E_RST,
        awready: 1'b1,
        wready: 1'b1,
        arready: 1'b1,
        default: '0
      };
    end else begin
      st_ff <= nxt_st;
    end
  end

  // outputs straight from flops
  assign s_axi_awready = st_ff.awready;
  assign s_axi_wready = st_ff.wready;
  assign s_axi_bvalid = st_ff.bvalid;
  assign s_axi_bresp = st_ff.bresp;
  assign s_axi_arready = st_ff.arready;
  assign s_axi_rvalid = st_ff.rvalid;
  assign s_axi_rdata = st_ff.rdata;
  assign s_axi_rresp = st_ff.rresp;
  assign irq = st_ff.irq;
  assign link_reinit_req = st_ff.reinit_req;

  // ****************************************************************
  // checks
  // ****************************************************************

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);

  sequence s_write_held;
    st_ff.aw_got && st_ff.w_got && !st_ff.bvalid;
  endsequence

  sequence s_write_answered;
    st_ff.bvalid && !st_ff.aw_got && !st_ff.w_got;
  endsequence

  property p_fifo_full;
    fifo_full_rise |=> st_ff.flags[BIT_PCFIFO];
  endproperty
  a_fifo_full: assert property (p_fifo_full) else $error("pcfifo flag not set");

  property p_xcvr_drop;
    ready_drop |=> st_ff.flags[BIT_XCVR_RDY];
  endproperty
  a_xcvr_drop: assert property (p_xcvr_drop) else $error("ready flag not set");

  property p_cmd_invalid;
    (st_ff.cmd_used && link_running && command_in.ready && !command_in.valid)
      |=> st_ff.flags[BIT_CMD] && (st_ff.irq || !st_ff.irq_en[BIT_CMD]);
  endproperty
  a_cmd_invalid: assert property (p_cmd_invalid) else $error("command flag not set");

  property p_frame_invalid;
    (st_ff.tp_used && link_running && sample_in.ready && !sample_in.valid)
      |=> st_ff.flags[BIT_FRAME_DATA];
  endproperty
  a_frame_invalid: assert property (p_frame_invalid) else $error("frame flag not set");

  property p_link_invalid;
    (link_running && link_data_in.ready && !link_data_in.valid) |=> st_ff.flags[BIT_LINK_DATA];
  endproperty
  a_link_invalid: assert property (p_link_invalid) else $error("link flag not set");

  property p_lemc;
    lemc_err |=> st_ff.flags[BIT_LEMC];
  endproperty
  a_lemc: assert property (p_lemc) else $error("sysref flag not set");

  property p_irq_gate;
    ##1 (st_ff.irq == |(st_ff.flags & st_ff.irq_en));
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("irq not gated by enable");

  property p_reset_values;
    $fell(srst) |-> (st_ff.irq_en == IRQ_EN_RST) && (st_ff.reinit_en == REINIT_EN_RST)
      && (st_ff.flags == FLAGS_RST);
  endproperty
  a_reset_values: assert property (p_reset_values) else $error("bad enable reset");

  property p_reinit_gate;
    st_ff.reinit_req |-> |(st_ff.flags & st_ff.reinit_en);
  endproperty
  a_reinit_gate: assert property (p_reinit_gate) else $error("reinit without enable");

  property p_reinit_off;
    (st_ff.reinit_en == '0) |=> !st_ff.reinit_req || $past(wr_fire);
  endproperty
  a_reinit_off: assert property (p_reinit_off) else $error("reinit while disabled");

  property p_gearbox;
    (|gearbox_over_flag) |=> st_ff.flags[BIT_GB_OVER];
  endproperty
  a_gearbox: assert property (p_gearbox) else $error("gearbox flag not set");

  property p_w1c;
    (s_write_held ##1 s_write_answered) |-> (st_ff.flags & $past(clr) & ~$past(ev)) == '0;
  endproperty
  a_w1c: assert property (p_w1c) else $error("write one did not clear");

  property p_sticky;
    (clr == '0) |=> ((st_ff.flags & $past(st_ff.flags)) == $past(st_ff.flags));
  endproperty
  a_sticky: assert property (p_sticky) else $error("flag dropped on its own");

  property p_reserved;
    st_ff.rvalid |-> (st_ff.rdata[31:16] == '0);
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bits not zero");

  property p_bhold;
    (st_ff.bvalid && !s_axi_bready) |=> st_ff.bvalid;
  endproperty
  a_bhold: assert property (p_bhold) else $error("write response dropped");

endmodule
